/* File: slice_consts.svh */
// Offsets, field positions and reset values of the logic slice registers.
// Assumes an APB master with 32-bit data and byte addressing.
`ifndef SLICE_CONSTS_SVH
`define SLICE_CONSTS_SVH

`define SLC_ADDR_W        12
`define SLC_OFF_LOWER_LUT 12'h000
`define SLC_OFF_UPPER_LUT 12'h004
`define SLC_OFF_MODE      12'h008
`define SLC_OFF_STATUS    12'h00C

`define SLC_LUT_W         16
`define SLC_MODE_W        17
`define SLC_LUT_RESET     16'h0000
`define SLC_MODE_RESET    17'h0_0000

`define SLC_ST_LOWER_LUT  0
`define SLC_ST_UPPER_LUT  1
`define SLC_ST_LOWER_Q    2
`define SLC_ST_UPPER_Q    3
`define SLC_ST_CARRY      4
`define SLC_ST_W          5

`endif

/* File: slice_pkg.sv */
// Types of the logic slice: table modes and the mode register layout.
// Layout order is most significant field first.
package slice_pkg;

    typedef enum logic [1:0] {
        LUT_LOGIC = 2'b00,
        LUT_RAM   = 2'b01,
        LUT_SHIFT = 2'b11
    } lut_mode_t;

    typedef struct packed {
        logic      upper_sum_sel;
        logic      lower_sum_sel;
        logic      shift_chain;
        logic      datain_route_en;
        logic      carry_init_sel;
        logic      upper_gen_and;
        logic      lower_gen_and;
        logic      upper_ff_bypass;
        logic      lower_ff_bypass;
        logic      rev_en;
        logic      upper_latch;
        logic      lower_latch;
        logic      dual_port;
        lut_mode_t upper_mode;
        lut_mode_t lower_mode;
    } slice_cfg_t;

endpackage : slice_pkg

/* File: logic_slice_lut_carry.sv */
// Logic slice: two four-input tables, storage elements, wide muxes,
// carry chain, bypass paths and an APB slave for configuration.
// Assumes fabric inputs synchronous to pclk and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "slice_consts.svh"

module logic_slice_lut_carry #(
    parameter bit MEMORY_CAPABLE = 1'b1
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SLC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [3:0]             lower_lut_select_inputs,
    input  wire logic [3:0]             upper_lut_select_inputs,
    input  wire logic                   lut_write_enable,
    input  wire logic                   lower_bypass_in,
    input  wire logic                   upper_bypass_in,
    input  wire logic                   carry_in_line,
    input  wire logic                   shift_cascade_in,
    input  wire logic                   storage_gate,
    input  wire logic [1:0]             neighbour_wide_in,
    output logic                        lower_comb_out,
    output logic                        upper_comb_out,
    output logic                        lower_registered_out,
    output logic                        upper_registered_out,
    output logic                        lower_bypass_out,
    output logic                        upper_bypass_out,
    output logic                        carry_out_line,
    output logic                        shift_cascade_out,
    output logic                        upper_datain_out,
    output logic                        five_input_wide_mux,
    output logic                        upper_wide_mux
);

    slice_pkg::slice_cfg_t         cfg_q;
    logic [`SLC_LUT_W-1:0]         lut_q [2];
    logic [3:0]                    sel [2];
    logic [`SLC_ADDR_W-1:0]        lut_off [2];
    slice_pkg::lut_mode_t          mode [2];
    logic [1:0]                    bypass;
    logic [1:0]                    lut_out;
    logic [1:0]                    ff_d;
    logic [1:0]                    ff_q;
    logic [1:0]                    st_out;
    logic [1:0]                    latch_mode;
    logic [1:0]                    ff_bypass;
    logic [1:0]                    gen_and;
    logic [1:0]                    gen;
    logic                          reverse_control;
    logic                          lut_wdata;
    logic                          carry_lower_in;
    logic                          carry_mid;
    logic                          lower_sum;
    logic                          upper_sum;
    logic                          apb_wr;
    logic                          apb_rd_setup;
    logic                          addr_hit;
    logic [31:0]                   rd_mux;
    logic [`SLC_ST_W-1:0]          status;

    assign sel[0]     = lower_lut_select_inputs;
    assign sel[1]     = upper_lut_select_inputs;
    assign lut_off[0] = `SLC_OFF_LOWER_LUT;
    assign lut_off[1] = `SLC_OFF_UPPER_LUT;
    assign bypass     = {upper_bypass_in, lower_bypass_in};
    assign latch_mode = {cfg_q.upper_latch, cfg_q.lower_latch};
    assign ff_bypass  = {cfg_q.upper_ff_bypass, cfg_q.lower_ff_bypass};
    assign gen_and    = {cfg_q.upper_gen_and, cfg_q.lower_gen_and};
    assign lut_wdata  = lower_bypass_in;

    // Logic-only slices ignore RAM and shift settings entirely
    assign mode[0] = MEMORY_CAPABLE ? cfg_q.lower_mode
                                    : slice_pkg::LUT_LOGIC;
    assign mode[1] = MEMORY_CAPABLE ? cfg_q.upper_mode
                                    : slice_pkg::LUT_LOGIC;

    assign reverse_control = cfg_q.rev_en & upper_bypass_in;

    // APB decode
    assign apb_wr       = psel & penable & pwrite;
    assign apb_rd_setup = psel & ~penable & ~pwrite;
    assign addr_hit     = (paddr == `SLC_OFF_LOWER_LUT)
                        | (paddr == `SLC_OFF_UPPER_LUT)
                        | (paddr == `SLC_OFF_MODE)
                        | (paddr == `SLC_OFF_STATUS);
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~addr_hit;

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            logic       ram_wr;
            logic       shift_wr;
            logic [3:0] wr_addr;
            logic       serial;

            if (h == 0) begin : g_lower
                assign ram_wr = mode[0] == slice_pkg::LUT_RAM;
                assign wr_addr = sel[0];
                assign serial = cfg_q.shift_chain ? shift_cascade_in
                                                  : lut_wdata;
            end else begin : g_upper
                // Dual port: upper copy follows lower writes, own reads
                assign ram_wr = cfg_q.dual_port
                              ? (mode[0] == slice_pkg::LUT_RAM)
                              : (mode[1] == slice_pkg::LUT_RAM);
                assign wr_addr = cfg_q.dual_port ? sel[0] : sel[1];
                assign serial = cfg_q.shift_chain ? lut_q[0][15]
                                                  : lut_wdata;
            end
            assign shift_wr = mode[h] == slice_pkg::LUT_SHIFT;

            // Software load wins over a fabric write in the same cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lut_q[h] <= `SLC_LUT_RESET;
                end else if (apb_wr && paddr == lut_off[h]) begin
                    lut_q[h] <= pwdata[`SLC_LUT_W-1:0];
                end else if (lut_write_enable && ram_wr) begin
                    lut_q[h][wr_addr] <= lut_wdata;
                end else if (lut_write_enable && shift_wr) begin
                    lut_q[h] <= {lut_q[h][14:0], serial};
                end
            end

            // Tap 0 is one cycle of delay, tap 15 is sixteen
            assign lut_out[h] = lut_q[h][sel[h]];

            assign ff_d[h] = ff_bypass[h] ? bypass[h]
                                          : lut_out[h];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ff_q[h] <= 1'b0;
                end else if (reverse_control) begin
                    ff_q[h] <= 1'b1;
                end else if (!latch_mode[h] || storage_gate) begin
                    ff_q[h] <= ff_d[h];
                end
            end

            // Latch is transparent while the gate is high
            assign st_out[h] = reverse_control ? 1'b1
                             : (latch_mode[h] && storage_gate) ? ff_d[h]
                             : ff_q[h];

            assign gen[h] = gen_and[h] ? (sel[h][0] & sel[h][1])
                                       : bypass[h];
        end
    endgenerate

    assign shift_cascade_out = lut_q[1][15];

    // Carry chain, lower stage then upper stage
    assign carry_lower_in = cfg_q.carry_init_sel ? lower_bypass_in
                                                 : carry_in_line;
    assign carry_mid      = lut_out[0] ? carry_lower_in : gen[0];
    assign carry_out_line = lut_out[1] ? carry_mid : gen[1];
    assign lower_sum      = lut_out[0] ^ carry_lower_in;
    assign upper_sum      = lut_out[1] ^ carry_mid;

    assign lower_comb_out = cfg_q.lower_sum_sel ? lower_sum
                                                : lut_out[0];
    assign upper_comb_out = cfg_q.upper_sum_sel ? upper_sum
                                                : lut_out[1];
    assign lower_registered_out = st_out[0];
    assign upper_registered_out = st_out[1];

    assign lower_bypass_out = lower_bypass_in;
    assign upper_bypass_out = upper_bypass_in;
    assign upper_datain_out = cfg_q.datain_route_en & upper_bypass_in;

    assign five_input_wide_mux = lower_bypass_in ? lut_out[1]
                                                 : lut_out[0];
    // Acts as the six-input mux in this position
    assign upper_wide_mux = upper_bypass_in ? neighbour_wide_in[1]
                                            : neighbour_wide_in[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `SLC_MODE_RESET;
        end else if (apb_wr && paddr == `SLC_OFF_MODE) begin
            cfg_q <= slice_pkg::slice_cfg_t'(pwdata[`SLC_MODE_W-1:0]);
        end
    end

    always_comb begin
        status                    = '0;
        status[`SLC_ST_LOWER_LUT] = lut_out[0];
        status[`SLC_ST_UPPER_LUT] = lut_out[1];
        status[`SLC_ST_LOWER_Q]   = st_out[0];
        status[`SLC_ST_UPPER_Q]   = st_out[1];
        status[`SLC_ST_CARRY]     = carry_out_line;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `SLC_OFF_LOWER_LUT: rd_mux[`SLC_LUT_W-1:0] = lut_q[0];
            `SLC_OFF_UPPER_LUT: rd_mux[`SLC_LUT_W-1:0] = lut_q[1];
            `SLC_OFF_MODE:      rd_mux[`SLC_MODE_W-1:0] = cfg_q;
            `SLC_OFF_STATUS:    rd_mux[`SLC_ST_W-1:0] = status;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in setup so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd_setup) begin
            prdata <= rd_mux;
        end
    end

endmodule : logic_slice_lut_carry
`default_nettype wire

/* File: slice_checker.sv */
// Port relations of the logic slice, checked as concurrent assertions.
// Bound into every logic_slice_lut_carry instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "slice_consts.svh"
module slice_checker (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SLC_ADDR_W-1:0] paddr,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   lut_write_enable,
    input wire logic                   lower_bypass_in,
    input wire logic                   upper_bypass_in,
    input wire logic [1:0]             neighbour_wide_in,
    input wire logic                   lower_bypass_out,
    input wire logic                   upper_bypass_out,
    input wire logic                   shift_cascade_out,
    input wire logic                   upper_datain_out,
    input wire logic                   upper_wide_mux
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_any;
    assign wr_any = lut_write_enable || (psel && penable && pwrite);
    sequence access_s;
        psel && penable;
    endsequence
    ready_access_a: assert property (access_s |-> pready)
        else $error("pready low in access phase");
    slverr_unmap_a: assert property (
        access_s ##0 (paddr > `SLC_OFF_STATUS) |-> pslverr)
        else $error("no error on unmapped address");
    slverr_phase_a: assert property (pslverr |-> access_s)
        else $error("error outside access phase");
    prdata_hold_a: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read setup");
    cascade_write_a: assert property (
        $changed(shift_cascade_out) |-> $past(wr_any))
        else $error("cascade out moved without write");
    wide_select_a: assert property (
        upper_wide_mux == neighbour_wide_in[upper_bypass_in])
        else $error("upper wide mux wrong input");
    bypass_pass_a: assert property (
        {lower_bypass_out, upper_bypass_out} ==
        {lower_bypass_in, upper_bypass_in})
        else $error("bypass output differs from input");
    datain_gate_a: assert property (
        upper_datain_out |-> upper_bypass_in)
        else $error("data-in output high without bypass");
endmodule : slice_checker
bind logic_slice_lut_carry slice_checker u_slice_chk (.*);
`default_nettype wire

/* File: nb_shift_stage.sv */
// Neighbouring slice shift table feeding the cascade input.
// Assumes it shifts on the slice clock and the shared write enable.
`timescale 1ns/1ps
`default_nettype none
module nb_shift_stage (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic shift_en,
    input  wire logic serial_in,
    output var  logic cascade_out
);
    logic [15:0] stage_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= 16'h0000;
        end else if (shift_en) begin
            stage_q <= {stage_q[14:0], serial_in};
        end
    end
    // Full 16 stages, so each neighbour adds a whole table of delay
    assign cascade_out = stage_q[15];
endmodule : nb_shift_stage
`default_nettype wire

/* File: logic_slice_lut_carry_tb_top.sv */
// Testbench of the logic slice: table cases, memory, shift, storage.
// Assumes the slice header, package, checker and neighbour stage model.
`timescale 1ns/1ps
`default_nettype none
`include "slice_consts.svh"
module logic_slice_lut_carry_tb_top;
    typedef struct {
        logic [15:0] lt, ut;
        slice_pkg::slice_cfg_t md;
        logic [3:0] ls, us;
        logic bx, ci;
        logic [3:0] exp;
    } row_t;
    row_t rows [4] = '{
        '{16'h8000, 16'h0001, 17'h0_0000, 4'hF, 4'h0, 1'b0, 1'b1, 4'hF},
        '{16'h8000, 16'h0001, 17'h0_0000, 4'hE, 4'h1, 1'b1, 1'b1, 4'h0},
        '{16'hFFFF, 16'hFFFF, 17'h1_8000, 4'h0, 4'h0, 1'b0, 1'b1, 4'hC},
        '{16'h0000, 16'hFFFF, 17'h0_9400, 4'h3, 4'h0, 1'b0, 1'b1, 4'h6}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ser;
    logic [`SLC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, obs;
    logic [3:0] lower_lut_select_inputs, upper_lut_select_inputs;
    logic lut_write_enable, lower_bypass_in, upper_bypass_in, carry_in_line;
    logic shift_cascade_in, storage_gate, lower_comb_out, upper_comb_out;
    logic lower_registered_out, upper_registered_out, lower_bypass_out;
    logic upper_bypass_out, carry_out_line, shift_cascade_out;
    logic upper_datain_out, five_input_wide_mux, upper_wide_mux;
    logic [1:0] neighbour_wide_in;
    int error_cnt = 0;
    int checked = 0;
    logic_slice_lut_carry dut (.*);
    nb_shift_stage nb (.pclk, .presetn, .shift_en(lut_write_enable),
        .serial_in(ser), .cascade_out(shift_cascade_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One enabled edge per call, so counts below are in shifts
    task automatic wr_bit(input logic b, input logic s);
        @(posedge pclk);
        lut_write_enable <= 1'b1;
        lower_bypass_in <= b;
        ser <= s;
        @(posedge pclk);
        lut_write_enable <= 1'b0;
        lower_bypass_in <= 1'b0;
        ser <= 1'b0;
    endtask : wr_bit
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ser} = '0;
        {lower_lut_select_inputs, upper_lut_select_inputs} = 8'h00;
        {lut_write_enable, lower_bypass_in, upper_bypass_in} = 3'b000;
        {carry_in_line, storage_gate} = 2'b00;
        neighbour_wide_in = 2'b10;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        $display("Test reset and unmapped done");
        foreach (rows[i]) begin
            apb(1'b1, `SLC_OFF_LOWER_LUT, 32'(rows[i].lt));
            apb(1'b1, `SLC_OFF_UPPER_LUT, 32'(rows[i].ut));
            apb(1'b1, `SLC_OFF_MODE, 32'(rows[i].md));
            lower_lut_select_inputs <= rows[i].ls;
            upper_lut_select_inputs <= rows[i].us;
            lower_bypass_in <= rows[i].bx;
            carry_in_line <= rows[i].ci;
            @(negedge pclk);
            obs = 32'({five_input_wide_mux, carry_out_line,
                upper_comb_out, lower_comb_out});
            chk(obs, 32'(rows[i].exp));
            apb(1'b0, `SLC_OFF_LOWER_LUT, 32'h0000_0000);
            chk(rd, 32'(rows[i].lt));
        end
        $display("Test table rows done");
        for (int a = 0; a < 12; a += 4) apb(1'b1, 12'(a), 32'h0000_0000);
        lower_lut_select_inputs <= 4'h5;
        upper_lut_select_inputs <= 4'h5;
        wr_bit(1'b1, 1'b0);
        apb(1'b0, `SLC_OFF_LOWER_LUT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `SLC_OFF_MODE, 32'h0000_0011);
        wr_bit(1'b1, 1'b0);
        apb(1'b0, `SLC_OFF_LOWER_LUT, 32'h0000_0000);
        chk(rd, 32'h0000_0020);
        @(negedge pclk);
        chk(32'({upper_comb_out, lower_comb_out}), 32'h0000_0003);
        $display("Test memory done");
        apb(1'b1, `SLC_OFF_LOWER_LUT, 32'h0000_0000);
        apb(1'b1, `SLC_OFF_MODE, 32'h0000_0003);
        lower_lut_select_inputs <= 4'hF;
        wr_bit(1'b1, 1'b0);
        repeat (14) wr_bit(1'b0, 1'b0);
        @(negedge pclk);
        chk(32'(lower_comb_out), 32'h0000_0000);
        wr_bit(1'b0, 1'b0);
        @(negedge pclk);
        chk(32'(lower_comb_out), 32'h0000_0001);
        apb(1'b1, `SLC_OFF_MODE, 32'h0000_400F);
        apb(1'b1, `SLC_OFF_LOWER_LUT, 32'h0000_0000);
        apb(1'b1, `SLC_OFF_UPPER_LUT, 32'h0000_0000);
        // Neighbour, lower and upper tables give 48 shifts
        wr_bit(1'b0, 1'b1);
        repeat (46) wr_bit(1'b0, 1'b0);
        @(negedge pclk);
        chk(32'(shift_cascade_out), 32'h0000_0000);
        wr_bit(1'b0, 1'b0);
        @(negedge pclk);
        chk(32'(shift_cascade_out), 32'h0000_0001);
        $display("Test shift done");
        apb(1'b1, `SLC_OFF_MODE, 32'h0000_2180);
        lower_bypass_in <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(lower_registered_out), 32'h0000_0001);
        @(posedge pclk);
        lower_bypass_in <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(lower_registered_out), 32'h0000_0000);
        @(posedge pclk);
        upper_bypass_in <= 1'b1;
        @(negedge pclk);
        obs = 32'({upper_datain_out, upper_registered_out,
            lower_registered_out, upper_bypass_out, upper_wide_mux});
        chk(obs, 32'h0000_001F);
        // Element left at 1, so a transparent 0 cannot come from q
        @(posedge pclk);
        upper_bypass_in <= 1'b0;
        lower_bypass_in <= 1'b1;
        apb(1'b1, `SLC_OFF_MODE, 32'h0000_0120);
        storage_gate <= 1'b1;
        lower_bypass_in <= 1'b0;
        @(negedge pclk);
        chk(32'(lower_registered_out), 32'h0000_0000);
        @(posedge pclk);
        storage_gate <= 1'b0;
        lower_bypass_in <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(32'(lower_registered_out), 32'h0000_0000);
        $display("Test storage done");
        complete_run();
    end
endmodule : logic_slice_lut_carry_tb_top
`default_nettype wire
